//--- hw/paer_event_regs.sv
// Application-side request register bank in front of the protocol controller.
// Assumes APB and controller done strobes, all on clk_sys_in.
//
// Notes on behaviour
// - Link-change hot-plug bit forwarded, then cleared.
// - Hot-plug bits 8..6: interlock, presence, latch.
// - Hot-plug bits 13..9: event slot.
// - Wake bit: leave L1/L2, send wake message.
// - Each request bit forwarded, cleared on controller done, except the L23 ready bit in auto mode.
// - Turn-off request only in root complex mode.
// - Without auto mode, L23 entry waits for ready bit.
// - Auto bit set: ready-for-L23 bit ignored.
// - Power bits 20..16: wake message function.
// - Wire bit 0 assert, bit 1 deassert, bits 20..16 function.
// - Vector trigger passes twelve-bit vector number.
// - Trigger starts on written 1, ignored while pending, clears on done.
// - Thirty-two vector triggers, one per endpoint.
// - Triggers: function 5..1, virtual 17..7, active flag 19.
// - Message trigger uses address, payload; slot bits 24..20.
// - Triggers honoured only in data-mover mode.
// - Message address two 32-bit halves, 32-bit payload.
// - Initiate bit runs one config access, clears on done.
// - Control bit 1: config read (0) or write (1).
// - Byte enables 5..2 qualify writes, any combination.
// - Ten-bit dword address placed at bits 15..6.
// - Target: function type, function, virtual function.
// - Read result in read-only register once initiate clears.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "paer_consts.svh"

module paer_event_regs (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  // Hot-plug events
  output logic [5:0] hp_event_req_out,
  input wire logic [5:0] hp_event_done_in,
  output logic [2:0] hp_slot_state_out,
  output logic [4:0] hp_slot_out,
  // Power management
  output logic pm_wake_req_out,
  output logic pm_turnoff_req_out,
  output logic pm_l23_ready_out,
  output logic pm_l23_auto_out,
  output logic [4:0] pm_func_out,
  input wire logic [2:0] pm_done_in,
  // Wire interrupt messages
  output logic [1:0] intx_req_out,
  output logic [4:0] intx_func_out,
  input wire logic [1:0] intx_done_in,
  // Message interrupt
  output logic msi_req_out,
  output logic [63:0] msi_addr_out,
  output logic [31:0] message_interrupt_payload_out,
  output logic [4:0] msi_pf_out,
  output logic [10:0] msi_vf_out,
  output logic msi_vf_active_out,
  output logic [4:0] msi_slot_out,
  input wire logic msi_done_in,
  // Vector interrupt
  output logic vec_req_out,
  output logic [4:0] vec_ep_out,
  output logic [11:0] vec_num_out,
  output logic [4:0] vec_pf_out,
  output logic [10:0] vec_vf_out,
  output logic vec_vf_active_out,
  input wire logic vec_done_in,
  // Indirect configuration access
  output logic cfg_req_out,
  output logic cfg_write_out,
  output logic [3:0] cfg_be_out,
  output logic [9:0] cfg_addr_out,
  output logic [2:0] cfg_ftype_out,
  output logic [4:0] cfg_pf_out,
  output logic [10:0] cfg_vf_out,
  output logic [4:0] cfg_slot_out,
  output logic [31:0] cfg_wdata_out,
  input wire logic [31:0] cfg_rdata_in,
  input wire logic cfg_done_in
);

  // --------------------
  // Field update with request bits
  // --------------------
  // Request bits set only from a written 1 while clear, clear only on done,
  // so a set and a done never meet.
  function automatic paer_pkg::paer_word_t merge(
    input paer_pkg::paer_word_t old,
    input paer_pkg::paer_word_t wd,
    input paer_pkg::paer_word_t fld,
    input paer_pkg::paer_word_t req,
    input paer_pkg::paer_word_t done,
    input logic wr
  );
    paer_pkg::paer_word_t f;
    paer_pkg::paer_word_t r;
    f = wr ? ((old & ~fld) | (wd & fld)) : old;
    r = (old & req & ~done) | (wr ? (wd & req & ~old) : `PAER_NONE);
    return (f & fld) | r;
  endfunction

  // --------------------
  // APB decode
  // --------------------
  paer_pkg::paer_word_t hp_q, hp_d, pm_q, pm_d, wi_q, wi_d;
  paer_pkg::paer_word_t msi_ctl_q, msi_ctl_d, msi_alo_q, msi_alo_d, msi_ahi_q, msi_ahi_d;
  paer_pkg::paer_word_t msi_dat_q, msi_dat_d, cfg_ctl_q, cfg_ctl_d, cfg_fn_q, cfg_fn_d;
  paer_pkg::paer_word_t cfg_wd_q, cfg_wd_d, cfg_rd_q, cfg_rd_d, mode_q, mode_d;
  paer_pkg::paer_word_t vec_q [32];
  paer_pkg::paer_word_t prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] lane_mask;
  logic access_wr;
  logic setup;
  logic vec_hit;
  logic hit;
  logic [31:0] rd_mux;
  logic rc_mode;
  logic dm_mode;
  logic [31:0] vec_done;

  assign setup = psel_in & ~penable_in;
  assign access_wr = psel_in & penable_in & pwrite_in;
  assign vec_hit = (paddr_in[11:7] == `PAER_VEC_PAGE);
  assign rc_mode = mode_q[`PAER_MODE_RC_BIT];
  assign dm_mode = mode_q[`PAER_MODE_DM_BIT];
  assign pready_out = 1'b1;
  assign prdata_out = prdata_q;
  assign pslverr_out = pslverr_q;

  generate
    for (genvar b = 0; b < 4; b++)
    begin : g_lane
      assign lane_mask[8*b +: 8] = {8{pstrb_in[b]}};
    end
  endgenerate

  // Read data and error are prepared in the setup cycle so they are flops
  always_comb
  begin
    hit = 1'b1;
    rd_mux = `PAER_NONE;
    if (vec_hit)
      rd_mux = vec_q[paddr_in[6:2]];
    else
    begin
      unique case ({paddr_in[11:2], 2'b00})
        `PAER_OFF_HP: rd_mux = hp_q;
        `PAER_OFF_PM: rd_mux = pm_q;
        `PAER_OFF_WI: rd_mux = wi_q;
        `PAER_OFF_MSI_CTL: rd_mux = msi_ctl_q;
        `PAER_OFF_MSI_ALO: rd_mux = msi_alo_q;
        `PAER_OFF_MSI_AHI: rd_mux = msi_ahi_q;
        `PAER_OFF_MSI_DAT: rd_mux = msi_dat_q;
        `PAER_OFF_CFG_CTL: rd_mux = cfg_ctl_q;
        `PAER_OFF_CFG_FN: rd_mux = cfg_fn_q;
        `PAER_OFF_CFG_WD: rd_mux = cfg_wd_q;
        `PAER_OFF_CFG_RD: rd_mux = cfg_rd_q;
        `PAER_OFF_MODE: rd_mux = mode_q;
        default: hit = 1'b0;
      endcase
    end
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (setup)
    begin
      prdata_d = pwrite_in ? `PAER_NONE : rd_mux;
      pslverr_d = ~hit;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      prdata_q <= `PAER_RESET_WORD;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // --------------------
  // Scalar registers
  // --------------------
  function automatic logic wr_at(input logic [11:0] off);
    return access_wr & ~vec_hit & ({paddr_in[11:2], 2'b00} == off);
  endfunction

  function automatic paer_pkg::paer_word_t lanes(input paer_pkg::paer_word_t old);
    return (old & ~lane_mask) | (pwdata_in & lane_mask);
  endfunction

  always_comb
  begin
    paer_pkg::paer_word_t pm_wd;
    paer_pkg::paer_word_t msi_wd;
    paer_pkg::paer_word_t pm_done;
    pm_wd = lanes(pm_q);
    if (!rc_mode)
      pm_wd[`PAER_PM_TURNOFF_BIT] = 1'b0;
    msi_wd = lanes(msi_ctl_q);
    if (!dm_mode)
      msi_wd[`PAER_TRIG_BIT] = 1'b0;
    pm_done = {29'd0, pm_done_in};
    if (pm_q[`PAER_PM_AUTO_BIT])
      pm_done[`PAER_PM_L23_BIT] = 1'b1;
    hp_d = merge(hp_q, lanes(hp_q), `PAER_HP_FLD, `PAER_HP_REQ,
                 {26'd0, hp_event_done_in}, wr_at(`PAER_OFF_HP));
    pm_d = merge(pm_q, pm_wd, `PAER_PM_FLD, `PAER_PM_REQ, pm_done,
                 wr_at(`PAER_OFF_PM));
    wi_d = merge(wi_q, lanes(wi_q), `PAER_WI_FLD, `PAER_WI_REQ,
                 {30'd0, intx_done_in}, wr_at(`PAER_OFF_WI));
    msi_ctl_d = merge(msi_ctl_q, msi_wd, `PAER_MSI_FLD, `PAER_TRIG_REQ,
                      {31'd0, msi_done_in}, wr_at(`PAER_OFF_MSI_CTL));
    msi_alo_d = wr_at(`PAER_OFF_MSI_ALO) ? lanes(msi_alo_q) : msi_alo_q;
    msi_ahi_d = wr_at(`PAER_OFF_MSI_AHI) ? lanes(msi_ahi_q) : msi_ahi_q;
    msi_dat_d = wr_at(`PAER_OFF_MSI_DAT) ? lanes(msi_dat_q) : msi_dat_q;
    cfg_ctl_d = merge(cfg_ctl_q, lanes(cfg_ctl_q), `PAER_CFG_CTL_FLD, `PAER_TRIG_REQ,
                      {31'd0, cfg_done_in}, wr_at(`PAER_OFF_CFG_CTL));
    cfg_fn_d = merge(cfg_fn_q, lanes(cfg_fn_q), `PAER_CFG_FN_FLD, `PAER_NONE,
                     `PAER_NONE, wr_at(`PAER_OFF_CFG_FN));
    cfg_wd_d = wr_at(`PAER_OFF_CFG_WD) ? lanes(cfg_wd_q) : cfg_wd_q;
    cfg_rd_d = cfg_rd_q;
    if (cfg_done_in && cfg_ctl_q[`PAER_CFG_INIT_BIT] && !cfg_ctl_q[`PAER_CFG_WRITE_BIT])
      cfg_rd_d = cfg_rdata_in;
    mode_d = merge(mode_q, lanes(mode_q), `PAER_MODE_FLD, `PAER_NONE,
                   `PAER_NONE, wr_at(`PAER_OFF_MODE));
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      hp_q <= `PAER_RESET_WORD;
      pm_q <= `PAER_RESET_WORD;
      wi_q <= `PAER_RESET_WORD;
      msi_ctl_q <= `PAER_RESET_WORD;
      msi_alo_q <= `PAER_RESET_WORD;
      msi_ahi_q <= `PAER_RESET_WORD;
      msi_dat_q <= `PAER_RESET_WORD;
      cfg_ctl_q <= `PAER_RESET_WORD;
      cfg_fn_q <= `PAER_RESET_WORD;
      cfg_wd_q <= `PAER_RESET_WORD;
      cfg_rd_q <= `PAER_RESET_WORD;
      mode_q <= `PAER_RESET_WORD;
    end
    else
    begin
      hp_q <= hp_d;
      pm_q <= pm_d;
      wi_q <= wi_d;
      msi_ctl_q <= msi_ctl_d;
      msi_alo_q <= msi_alo_d;
      msi_ahi_q <= msi_ahi_d;
      msi_dat_q <= msi_dat_d;
      cfg_ctl_q <= cfg_ctl_d;
      cfg_fn_q <= cfg_fn_d;
      cfg_wd_q <= cfg_wd_d;
      cfg_rd_q <= cfg_rd_d;
      mode_q <= mode_d;
    end
  end

  // --------------------
  // Vector trigger registers, one per endpoint
  // --------------------
  generate
    for (genvar e = 0; e < 32; e++)
    begin : g_vec
      paer_pkg::paer_word_t vec_d;
      always_comb
      begin
        paer_pkg::paer_word_t wd;
        wd = lanes(vec_q[e]);
        if (!dm_mode)
          wd[`PAER_TRIG_BIT] = 1'b0;
        vec_d = merge(vec_q[e], wd, `PAER_VEC_FLD, `PAER_TRIG_REQ,
                      {31'd0, vec_done[e]},
                      access_wr & vec_hit & (paddr_in[6:2] == 5'(e)));
      end
      always_ff @(posedge clk_sys_in)
      begin
        if (sys_rst_in)
          vec_q[e] <= `PAER_RESET_WORD;
        else
          vec_q[e] <= vec_d;
      end
    end
  endgenerate

  // --------------------
  // Vector issue engine
  // --------------------
  // Lowest pending endpoint first; fields are copied at pick so a later
  // write cannot alter an offered interrupt.
  paer_pkg::paer_vec_state_t vst_q, vst_d;
  logic [4:0] vsel_q, vsel_d;
  logic [11:0] vnum_q, vnum_d;
  logic [4:0] vpf_q, vpf_d;
  logic [10:0] vvf_q, vvf_d;
  logic vvfa_q, vvfa_d;

  always_comb
  begin
    logic found;
    found = 1'b0;
    vst_d = vst_q;
    vsel_d = vsel_q;
    vnum_d = vnum_q;
    vpf_d = vpf_q;
    vvf_d = vvf_q;
    vvfa_d = vvfa_q;
    vec_done = `PAER_NONE;
    unique case (vst_q)
      paer_pkg::PAER_VEC_IDLE:
      begin
        for (int i = 31; i >= 0; i--)
        begin
          if (vec_q[i][`PAER_TRIG_BIT])
          begin
            found = 1'b1;
            vsel_d = 5'(i);
          end
        end
        if (found)
        begin
          vst_d = paer_pkg::PAER_VEC_ISSUE;
          vnum_d = vec_q[vsel_d][`PAER_VEC_NUM_LSB +: 12];
          vpf_d = vec_q[vsel_d][`PAER_TRIG_PF_LSB +: 5];
          vvf_d = vec_q[vsel_d][`PAER_TRIG_VF_LSB +: 11];
          vvfa_d = vec_q[vsel_d][`PAER_TRIG_VFA_BIT];
        end
      end
      paer_pkg::PAER_VEC_ISSUE:
      begin
        if (vec_done_in)
        begin
          vec_done[vsel_q] = 1'b1;
          vst_d = paer_pkg::PAER_VEC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      vst_q <= paer_pkg::PAER_VEC_IDLE;
      vsel_q <= 5'h0;
      vnum_q <= 12'h000;
      vpf_q <= 5'h0;
      vvf_q <= 11'h000;
      vvfa_q <= 1'b0;
    end
    else
    begin
      vst_q <= vst_d;
      vsel_q <= vsel_d;
      vnum_q <= vnum_d;
      vpf_q <= vpf_d;
      vvf_q <= vvf_d;
      vvfa_q <= vvfa_d;
    end
  end

  // --------------------
  // Controller-facing outputs
  // --------------------
  assign hp_event_req_out = hp_q[5:0];
  assign hp_slot_state_out = hp_q[`PAER_HP_STATE_LSB +: 3];
  assign hp_slot_out = hp_q[`PAER_HP_SLOT_LSB +: 5];
  assign pm_wake_req_out = pm_q[`PAER_PM_WAKE_BIT];
  assign pm_turnoff_req_out = pm_q[`PAER_PM_TURNOFF_BIT];
  assign pm_l23_auto_out = pm_q[`PAER_PM_AUTO_BIT];
  assign pm_l23_ready_out = pm_q[`PAER_PM_L23_BIT] & ~pm_q[`PAER_PM_AUTO_BIT];
  assign pm_func_out = pm_q[`PAER_FUNC_LSB +: 5];
  assign intx_req_out = wi_q[1:0];
  assign intx_func_out = wi_q[`PAER_FUNC_LSB +: 5];
  assign msi_req_out = msi_ctl_q[`PAER_TRIG_BIT];
  assign msi_addr_out = {msi_ahi_q, msi_alo_q};
  assign message_interrupt_payload_out = msi_dat_q;
  assign msi_pf_out = msi_ctl_q[`PAER_TRIG_PF_LSB +: 5];
  assign msi_vf_out = msi_ctl_q[`PAER_TRIG_VF_LSB +: 11];
  assign msi_vf_active_out = msi_ctl_q[`PAER_TRIG_VFA_BIT];
  assign msi_slot_out = msi_ctl_q[`PAER_MSI_SLOT_LSB +: 5];
  assign vec_req_out = (vst_q == paer_pkg::PAER_VEC_ISSUE);
  assign vec_ep_out = vsel_q;
  assign vec_num_out = vnum_q;
  assign vec_pf_out = vpf_q;
  assign vec_vf_out = vvf_q;
  assign vec_vf_active_out = vvfa_q;
  assign cfg_req_out = cfg_ctl_q[`PAER_CFG_INIT_BIT];
  assign cfg_write_out = cfg_ctl_q[`PAER_CFG_WRITE_BIT];
  assign cfg_be_out = cfg_ctl_q[`PAER_CFG_BE_LSB +: 4];
  assign cfg_addr_out = cfg_ctl_q[`PAER_CFG_ADDR_LSB +: 10];
  assign cfg_ftype_out = cfg_fn_q[`PAER_CFG_TYPE_LSB +: 3];
  assign cfg_pf_out = cfg_fn_q[`PAER_CFG_PF_LSB +: 5];
  assign cfg_vf_out = cfg_fn_q[`PAER_CFG_VF_LSB +: 11];
  assign cfg_slot_out = cfg_fn_q[`PAER_CFG_SLOT_LSB +: 5];
  assign cfg_wdata_out = cfg_wd_q;

endmodule // paer_event_regs

//--- hw/paer_consts.svh
// Offsets, fields, masks and reset values of the request bank.
// Assumes a 12-bit APB byte address and 32-bit data, one register per word.
`ifndef PAER_CONSTS_SVH
`define PAER_CONSTS_SVH

// --------------------
// Register byte offsets
// --------------------
`define PAER_OFF_HP 12'h000
`define PAER_OFF_PM 12'h004
`define PAER_OFF_WI 12'h008
`define PAER_OFF_MSI_CTL 12'h00C
`define PAER_OFF_MSI_ALO 12'h010
`define PAER_OFF_MSI_AHI 12'h014
`define PAER_OFF_MSI_DAT 12'h018
`define PAER_OFF_CFG_CTL 12'h01C
`define PAER_OFF_CFG_FN 12'h020
`define PAER_OFF_CFG_WD 12'h024
`define PAER_OFF_CFG_RD 12'h028
`define PAER_OFF_MODE 12'h02C
// Vector triggers: 0x080 + 4*endpoint, selected by paddr[11:7]
`define PAER_VEC_PAGE 5'h01
`define PAER_RESET_WORD 32'h0000_0000

// --------------------
// Writable field masks and request-bit masks
// --------------------
`define PAER_HP_FLD 32'h0000_3FC0
`define PAER_HP_REQ 32'h0000_003F
`define PAER_PM_FLD 32'h001F_0008
`define PAER_PM_REQ 32'h0000_0007
`define PAER_WI_FLD 32'h001F_0000
`define PAER_WI_REQ 32'h0000_0003
`define PAER_VEC_FLD 32'hFFFB_FFBE
`define PAER_MSI_FLD 32'h01FB_FFBE
`define PAER_TRIG_REQ 32'h0000_0001
`define PAER_CFG_CTL_FLD 32'h0000_FFFE
`define PAER_CFG_FN_FLD 32'h03EF_FEFF
`define PAER_MODE_FLD 32'h0000_0003
`define PAER_NONE 32'h0000_0000

// --------------------
// Field positions
// --------------------
`define PAER_HP_STATE_LSB 6
`define PAER_HP_SLOT_LSB 9
`define PAER_PM_WAKE_BIT 0
`define PAER_PM_TURNOFF_BIT 1
`define PAER_PM_L23_BIT 2
`define PAER_PM_AUTO_BIT 3
`define PAER_FUNC_LSB 16
`define PAER_TRIG_BIT 0
`define PAER_TRIG_PF_LSB 1
`define PAER_TRIG_VF_LSB 7
`define PAER_TRIG_VFA_BIT 19
`define PAER_VEC_NUM_LSB 20
`define PAER_MSI_SLOT_LSB 20
`define PAER_CFG_INIT_BIT 0
`define PAER_CFG_WRITE_BIT 1
`define PAER_CFG_BE_LSB 2
`define PAER_CFG_ADDR_LSB 6
`define PAER_CFG_TYPE_LSB 0
`define PAER_CFG_PF_LSB 3
`define PAER_CFG_VF_LSB 9
`define PAER_CFG_SLOT_LSB 21
`define PAER_MODE_RC_BIT 0
`define PAER_MODE_DM_BIT 1

`endif

//--- hw/paer_pkg.sv
// Types shared by the event request bank.
// Assumes nothing beyond a SystemVerilog tool.
package paer_pkg;

  // --------------------
  // Vector trigger engine states
  // --------------------
  typedef enum logic [0:0] {
    PAER_VEC_IDLE = 1'b0,
    PAER_VEC_ISSUE = 1'b1
  } paer_vec_state_t;

  typedef logic [31:0] paer_word_t;

endpackage

//--- bench/paer_props.sv
// Port-level checks for the request bank.
// Bound to each bank instance; one clock, synchronous reset.
`timescale 1ns/1ps

module paer_props (
  // Clock, reset and bus
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pslverr_out,
  // Requests and answers
  input wire logic [5:0] hp_event_req_out,
  input wire logic [5:0] hp_event_done_in,
  input wire logic pm_wake_req_out,
  input wire logic pm_l23_ready_out,
  input wire logic pm_l23_auto_out,
  input wire logic [2:0] pm_done_in,
  input wire logic msi_req_out,
  input wire logic msi_done_in,
  input wire logic vec_req_out,
  input wire logic vec_done_in,
  input wire logic [4:0] vec_ep_out,
  input wire logic [11:0] vec_num_out,
  input wire logic cfg_req_out,
  input wire logic cfg_done_in
);
  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  property p_hp_hold; hp_event_req_out[5] && !hp_event_done_in[5] |=> hp_event_req_out[5]; endproperty
  a_hp_hold: assert property (p_hp_hold) else $error("link change dropped early");
  property p_hp_clr; hp_event_req_out[5] && hp_event_done_in[5] |=> !hp_event_req_out[5]; endproperty
  a_hp_clr: assert property (p_hp_clr) else $error("link change not cleared");
  property p_wake; pm_wake_req_out && pm_done_in[0] |=> !pm_wake_req_out; endproperty
  a_wake: assert property (p_wake) else $error("wake request not cleared");
  property p_auto; pm_l23_auto_out |-> !pm_l23_ready_out; endproperty
  a_auto: assert property (p_auto) else $error("l23 ready shown in auto mode");
  property p_msi; msi_req_out && !msi_done_in |=> msi_req_out; endproperty
  a_msi: assert property (p_msi) else $error("message trigger dropped");
  property p_vec;
    vec_req_out && !vec_done_in |=> vec_req_out && $stable(vec_num_out) && $stable(vec_ep_out);
  endproperty
  a_vec: assert property (p_vec) else $error("vector offer changed");
  property p_vgap; vec_req_out && vec_done_in |=> !vec_req_out; endproperty
  a_vgap: assert property (p_vgap) else $error("vector offer not withdrawn");
  property p_cfg;
    $rose(cfg_req_out) |-> $past(psel_in) && $past(penable_in) && $past(pwrite_in) &&
      $past(pwdata_in[0]) && $past(paddr_in) == 12'h01C;
  endproperty
  a_cfg: assert property (p_cfg) else $error("access started without write");
  property p_cfgc; cfg_req_out && cfg_done_in |=> !cfg_req_out; endproperty
  a_cfgc: assert property (p_cfgc) else $error("initiate not cleared");
  property p_err; psel_in && !penable_in && paddr_in == 12'h030 |=> pslverr_out; endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");
  c_vec: cover property (vec_req_out && vec_done_in);
  c_cfg: cover property (cfg_req_out && cfg_done_in);
  c_hp: cover property (hp_event_req_out[5] && hp_event_done_in[5]);
endmodule // paer_props

bind paer_event_regs paer_props u_props (.*);

//--- bench/paer_ctl_model.sv
// Controller model: answers all pending requests after dly_in + 1 cycles.
// Assumes request levels from the bank on the same clock.
`timescale 1ns/1ps

module paer_ctl_model #(
  parameter logic [31:0] RD_VAL = 32'h5A5A_0F0F
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Requests and answers
  input wire logic [13:0] req_in,
  input wire logic [3:0] dly_in,
  output logic [13:0] done_out,
  output logic [31:0] rdata_out
);
  // --------------------
  // Answer timing
  // --------------------
  logic [3:0] cnt_q, cnt_d;
  logic [13:0] done_q, done_d;
  always_comb
  begin
    cnt_d = (|req_in && done_q == 14'h0) ? cnt_q + 4'h1 : 4'h0;
    done_d = (cnt_q == dly_in) ? (req_in & ~done_q) : 14'h0;
    if (sys_rst_in)
    begin
      cnt_d = 4'h0;
      done_d = 14'h0;
    end
  end
  always_ff @(posedge clk_sys_in)
  begin
    cnt_q <= cnt_d;
    done_q <= done_d;
  end
  assign done_out = done_q;
  // Inverted outside the done pulse so stale data shows
  assign rdata_out = done_q[0] ? RD_VAL : ~RD_VAL;
endmodule // paer_ctl_model

//--- bench/tb.sv
// Self-checking bench for the request bank and controller model.
// Assumes bank and model share clk_sys_in.
`timescale 1ns/1ps
`include "paer_consts.svh"
`define CHK(n, e, g) \
  begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end

module tb;
  logic clk_sys_in, sys_rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [11:0] paddr_in, vec_num_out;
  logic [31:0] pwdata_in, prdata_out, message_interrupt_payload_out, cfg_wdata_out, cfg_rdata_in, rd;
  logic [3:0] pstrb_in, cfg_be_out, dly;
  logic [5:0] hp_event_req_out, hp_event_done_in;
  logic [2:0] hp_slot_state_out, pm_done_in, cfg_ftype_out;
  logic [4:0] hp_slot_out, pm_func_out, intx_func_out, msi_pf_out, msi_slot_out;
  logic [4:0] vec_ep_out, vec_pf_out, cfg_pf_out, cfg_slot_out;
  logic pm_wake_req_out, pm_turnoff_req_out, pm_l23_ready_out, pm_l23_auto_out, perr;
  logic [1:0] intx_req_out, intx_done_in;
  logic msi_req_out, msi_vf_active_out, msi_done_in, vec_req_out, vec_vf_active_out;
  logic vec_done_in, cfg_req_out, cfg_write_out, cfg_done_in;
  logic [63:0] msi_addr_out;
  logic [10:0] msi_vf_out, vec_vf_out, cfg_vf_out;
  logic [9:0] cfg_addr_out;
  logic [13:0] done;
  int err_total = 0, tests_run = 0, cyc = 0, i;
  localparam logic [31:0] RDV = 32'h5A5A_0F0F;

  paer_event_regs dut (.*);
  paer_ctl_model #(.RD_VAL(RDV)) mdl (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .req_in({hp_event_req_out, pm_l23_ready_out, pm_turnoff_req_out, pm_wake_req_out,
    intx_req_out, msi_req_out, vec_req_out, cfg_req_out}), .dly_in(dly), .done_out(done),
    .rdata_out(cfg_rdata_in));
  assign {hp_event_done_in, pm_done_in, intx_done_in, msi_done_in, vec_done_in, cfg_done_in} = done;

  // --------------------
  // Bus and check helpers
  // --------------------
  initial
  begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    @(posedge clk_sys_in);
    while (pready_out !== 1'b1) @(posedge clk_sys_in);
    rd = prdata_out;
    perr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task chk_rd(input logic [11:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(n, e, rd);
  endtask
  // Polls: controller latency is free
  task wait_clr(input logic [11:0] a, input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000);
    for (i = 0; i < 40 && (rd & m) !== 32'h0000_0000; i++) apb(1'b0, a, 32'h0000_0000);
    `CHK("request clear", 32'h0000_0000, rd & m);
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_total++;
      conclude();
    end
  end

  // --------------------
  // Scenarios
  // --------------------
  task t_reset;
    for (int a = 0; a <= 'h2C; a += 4) chk_rd(a[11:0], 32'h0000_0000, "reset");
    apb(1'b1, 12'h030, 32'hFFFF_FFFF);
    chk_rd(12'h030, 32'h0000_0000, "unmapped");
    `CHK("slverr", 1'b1, perr);
  endtask
  task t_hp;
    apb(1'b1, `PAER_OFF_HP, 32'hFFFF_FFC0);
    chk_rd(`PAER_OFF_HP, 32'h0000_3FC0, "hp fields");
    apb(1'b1, `PAER_OFF_HP, 32'h0000_14A0);
    @(negedge clk_sys_in);
    `CHK("hp req", 6'h20, hp_event_req_out);
    `CHK("hp state", 3'b010, hp_slot_state_out);
    `CHK("hp slot", 5'h0A, hp_slot_out);
    wait_clr(`PAER_OFF_HP, 32'h0000_003F);
    pstrb_in <= 4'h1;
    apb(1'b1, `PAER_OFF_HP, 32'hFFFF_FFFF);
    pstrb_in <= 4'hF;
    @(negedge clk_sys_in);
    `CHK("hp all", 6'h3F, hp_event_req_out);
    wait_clr(`PAER_OFF_HP, 32'h0000_003F);
    chk_rd(`PAER_OFF_HP, 32'h0000_14C0, "hp keep");
  endtask
  task t_pm;
    apb(1'b1, `PAER_OFF_PM, 32'h0000_0002);
    @(negedge clk_sys_in);
    `CHK("turnoff ep", 1'b0, pm_turnoff_req_out);
    apb(1'b1, `PAER_OFF_MODE, 32'h0000_0001);
    apb(1'b1, `PAER_OFF_PM, 32'h0005_0003);
    @(negedge clk_sys_in);
    `CHK("turnoff rc", 1'b1, pm_turnoff_req_out);
    `CHK("wake", 1'b1, pm_wake_req_out);
    `CHK("pm func", 5'h05, pm_func_out);
    wait_clr(`PAER_OFF_PM, 32'h0000_0003);
    apb(1'b1, `PAER_OFF_PM, 32'h0000_0004);
    @(negedge clk_sys_in);
    `CHK("l23", 1'b1, pm_l23_ready_out);
    wait_clr(`PAER_OFF_PM, 32'h0000_0004);
    apb(1'b1, `PAER_OFF_PM, 32'h0000_000C);
    @(negedge clk_sys_in);
    `CHK("l23 auto", 2'b10, {pm_l23_auto_out, pm_l23_ready_out});
    chk_rd(`PAER_OFF_PM, 32'h0000_0008, "pm auto");
    apb(1'b1, `PAER_OFF_PM, 32'h0000_0000);
  endtask
  task t_intx;
    apb(1'b1, `PAER_OFF_WI, 32'hFFFF_FFFF);
    @(negedge clk_sys_in);
    `CHK("intx", 2'b11, intx_req_out);
    `CHK("intx func", 5'h1F, intx_func_out);
    wait_clr(`PAER_OFF_WI, 32'h0000_0003);
    chk_rd(`PAER_OFF_WI, 32'h001F_0000, "intx rsv");
  endtask
  task t_msi;
    apb(1'b1, `PAER_OFF_MSI_CTL, 32'h0000_0001);
    @(negedge clk_sys_in);
    `CHK("msi no dm", 1'b0, msi_req_out);
    apb(1'b1, `PAER_OFF_MSI_ALO, 32'h1234_5678);
    apb(1'b1, `PAER_OFF_MSI_AHI, 32'h9ABC_DEF0);
    apb(1'b1, `PAER_OFF_MSI_DAT, 32'h0BAD_F00D);
    apb(1'b1, `PAER_OFF_MODE, 32'h0000_0003);
    dly <= 4'hF;
    apb(1'b1, `PAER_OFF_MSI_CTL, 32'h0048_0185);
    @(negedge clk_sys_in);
    `CHK("msi req", 1'b1, msi_req_out);
    `CHK("msi addr", 64'h9ABC_DEF0_1234_5678, msi_addr_out);
    `CHK("message_interrupt_payload", 32'h0BAD_F00D, message_interrupt_payload_out);
    `CHK("msi fn", {5'h02, 11'h003, 1'b1}, {msi_pf_out, msi_vf_out, msi_vf_active_out});
    `CHK("msi slot", 5'h04, msi_slot_out);
    apb(1'b1, `PAER_OFF_MSI_CTL, 32'h0048_0185);
    wait_clr(`PAER_OFF_MSI_CTL, 32'h0000_0001);
    dly <= 4'h3;
    repeat (20) @(negedge clk_sys_in);
    `CHK("msi once", 1'b0, msi_req_out);
  endtask
  task t_vec;
    for (int e = 0; e < 32; e += 31)
    begin
      apb(1'b1, 12'h080 + 12'(e * 4), {12'h100 + 12'(e), 20'h8_0083});
      for (i = 0; i < 8 && vec_req_out !== 1'b1; i++) @(negedge clk_sys_in);
      `CHK("vec req", 1'b1, vec_req_out);
      `CHK("vec ep", 5'(e), vec_ep_out);
      `CHK("vec num", 12'h100 + 12'(e), vec_num_out);
      `CHK("vec fn", {5'h01, 11'h001, 1'b1},
        {vec_pf_out, vec_vf_out, vec_vf_active_out});
      wait_clr(12'h080 + 12'(e * 4), 32'h0000_0001);
    end
  endtask
  task t_cfg;
    apb(1'b1, `PAER_OFF_CFG_WD, 32'hCAFE_0123);
    apb(1'b1, `PAER_OFF_CFG_FN, 32'h0060_0A11);
    apb(1'b1, `PAER_OFF_CFG_CTL, 32'h0000_556B);
    @(negedge clk_sys_in);
    `CHK("cfg req", 2'b11, {cfg_req_out, cfg_write_out});
    `CHK("cfg be", 4'hA, cfg_be_out);
    `CHK("cfg addr", 10'h155, cfg_addr_out);
    `CHK("cfg fn", {3'h1, 5'h02, 11'h005, 5'h03},
      {cfg_ftype_out, cfg_pf_out, cfg_vf_out, cfg_slot_out});
    `CHK("cfg wdata", 32'hCAFE_0123, cfg_wdata_out);
    wait_clr(`PAER_OFF_CFG_CTL, 32'h0000_0001);
    apb(1'b1, `PAER_OFF_CFG_CTL, 32'h0000_0001);
    wait_clr(`PAER_OFF_CFG_CTL, 32'h0000_0001);
    chk_rd(`PAER_OFF_CFG_RD, RDV, "cfg rdata");
    apb(1'b1, `PAER_OFF_CFG_RD, 32'h0000_0000);
    chk_rd(`PAER_OFF_CFG_RD, RDV, "cfg ro");
  endtask

  initial
  begin
    {psel_in, penable_in, pwrite_in, sys_rst_in} = 4'b0001;
    paddr_in = 12'h000;
    pwdata_in = 32'h0000_0000;
    pstrb_in = 4'hF;
    dly = 4'h3;
    repeat (12) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_hp();
    t_pm();
    t_intx();
    t_msi();
    t_vec();
    t_cfg();
    conclude();
  end
endmodule // tb
